// ---- design/i2ccf_pkg.sv ----
// Constants, register map and state encodings of the configuration port.
package i2ccf_pkg;

  // Bus clock range that the oversampling front end is built for.
  localparam int BUS_MIN_KHZ = 50;
  localparam int BUS_MAX_KHZ = 1000;
  localparam int CLK_HZ      = 50_000_000;

  // Register offsets on the wire.
  localparam logic [7:0] OFF_ON_OFF      = 8'h02;
  localparam logic [7:0] OFF_COMMIT      = 8'h15;
  localparam logic [7:0] OFF_RESTORE     = 8'h16;
  localparam logic [7:0] OFF_TURN_ON_DELAY   = 8'h60;
  localparam logic [7:0] OFF_SOFT_START  = 8'h61;
  localparam logic [7:0] OFF_TURN_OFF_DELAY  = 8'h64;
  localparam logic [7:0] OFF_SOFT_STOP   = 8'h65;
  localparam logic [7:0] OFF_SYSCFG      = 8'hA0;
  localparam logic [7:0] OFF_REGBUS_ADDR = 8'hA1;
  localparam logic [7:0] OFF_TARGET_ADDR = 8'hA2;
  localparam logic [7:0] OFF_VOUT_OFFSET = 8'hA8;
  localparam logic [7:0] OFF_LOCK        = 8'hB1;
  localparam logic [7:0] OFF_MAXCAP_H    = 8'hBD;
  localparam logic [7:0] OFF_MAXCAP_L    = 8'hBE;
  localparam logic [7:0] OFF_PROTOCOL    = 8'hC2;

  // Storable registers, in the order they are walked through the NVM.
  localparam int         NREG            = 12;
  localparam int         IDXW            = 4;
  localparam logic [3:0] IDX_ON_OFF      = 4'h0;
  localparam logic [3:0] IDX_TURN_ON_DELAY   = 4'h1;
  localparam logic [3:0] IDX_SOFT_START  = 4'h2;
  localparam logic [3:0] IDX_TURN_OFF_DELAY  = 4'h3;
  localparam logic [3:0] IDX_SOFT_STOP   = 4'h4;
  localparam logic [3:0] IDX_MAXCAP_H    = 4'h5;
  localparam logic [3:0] IDX_MAXCAP_L    = 4'h6;
  localparam logic [3:0] IDX_SYSCFG      = 4'h7;
  localparam logic [3:0] IDX_REGBUS_ADDR = 4'h8;
  localparam logic [3:0] IDX_TARGET_ADDR = 4'h9;
  localparam logic [3:0] IDX_VOUT_OFFSET = 4'hA;
  localparam logic [3:0] IDX_PROTOCOL    = 4'hB;
  localparam logic [3:0] IDX_LAST        = 4'hB;

  // Reset values.
  localparam logic [7:0] RST_ON_OFF = 8'h40;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // Field positions.
  localparam int         ONOFF_PIN_CTRL_BIT   = 6;
  localparam int         SYSCFG_ADDR_OVRD_BIT = 0;
  localparam int         OUTCTL_LSB           = 3;
  localparam logic [1:0] OUTCTL_OFFSET_MODE   = 2'h1;
  localparam logic [7:0] SYSCFG_STAGE_MASK    = 8'hFC;
  localparam logic [7:0] PROTOCOL_STAGE_MASK  = 8'h01;
  localparam logic [7:0] FULL_MASK            = 8'hFF;
  localparam int         ACTION_BIT           = 0;
  localparam logic [2:0] STRAP_ADDR_HIGH      = 3'h7;
  localparam logic       RW_WRITE             = 1'b0;

  // NVM store duration.
  localparam int STORE_TIME_MS = 150;
  localparam int STORE_CYCLES  = STORE_TIME_MS * (CLK_HZ / 1000);

  // Unlock sequence length.
  localparam int PASS_COUNT = 2;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RX      = 3'b001,
    ST_ACKPEND = 3'b010,
    ST_ACK     = 3'b011,
    ST_TX      = 3'b100,
    ST_TXREL   = 3'b101,
    ST_MACK    = 3'b110
  } i2ccf_bus_type;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10,
    PH_READ = 2'b11
  } i2ccf_phase_type;

  typedef enum logic [2:0] {
    NV_INIT    = 3'b000,
    NV_IDLE    = 3'b001,
    NV_STORE   = 3'b010,
    NV_WAIT    = 3'b011,
    NV_RESTORE = 3'b100
  } i2ccf_nvm_type;

endpackage

// ---- design/i2ccf_port.sv ----
// Target-side configuration port with address strap, write lock, staging and NVM commit.
// Functional notes
// - Bus clock from 50 kHz to 1 MHz, all three speed modes.
// - Writes never reach NVM by themselves; store command 15h commits them.
// - Default target address comes from the strap, 0x70 to 0x7F.
// - Sixteen strap levels; short gives 1110000, open pin 1111111.
// - First byte is seven address bits then read/write, 0 for write.
// - Programmed address register holds any value 00h to 7Fh in bits 6:0.
// - Override bit 0 of A0h selects the programmed address over the strap.
// - Bit 0 write to the store command starts a 150 ms store.
// - Override bit and programmed address act only after store and power-on.
// - After power-on all writable registers except B1h are locked and writes to them get NACK.
// - Reads are acknowledged except during the power-on load, and return the register byte.
// - Correct passcodes in order unlock subsequent writes.
// - Ordinary accepted writes take effect immediately.
// - While switching, writes to 16h, 60h, 61h, 64h, 65h, BDh, BEh get NACK.
// - Always-on mode refuses NVM restores of switching-protected registers.
// - Staged fields apply now if not switching, else when switching stops.
// - Reads of staged registers return the latest acknowledged value.
// - Staged set: A0h fields, A1h, C2h select, A8h when output control is 01b.
// - Always-on mode keeps NVM values of staged fields staged until that register is next written.
// - On/off configuration resets to 40h, enable pin control only.
// - Restore reloads all storable registers from NVM, only the switching-unprotected ones in always-on mode.
`timescale 1ns/10ps

module i2ccf_port
  import i2ccf_pkg::*;
#(
  parameter int                        STORE_WAIT = STORE_CYCLES,
  parameter logic [PASS_COUNT*8-1:0]   PASSCODES  = 16'h5AC3
)
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output wire logic                    sda_o,
  output wire logic                    sda_oe,
  input  wire logic [3:0]              strap_level,
  input  wire logic                    switching_en,
  output logic      [IDXW-1:0]         nvm_addr,
  output logic      [7:0]              nvm_wdata,
  output logic                         nvm_we,
  input  wire logic [7:0]              nvm_rdata,
  output wire logic [6:0]              target_address,
  output wire logic                    regs_unlocked,
  output wire logic                    nvm_busy,
  output logic      [NREG*8-1:0]       cfg_active
);

  localparam int TMRW = $clog2(STORE_WAIT + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register lookup and per-register class.

  function automatic logic [IDXW:0] reg_lookup(input logic [7:0] off);
    unique case (off)
      OFF_ON_OFF:      reg_lookup = {1'b1, IDX_ON_OFF};
      OFF_TURN_ON_DELAY:   reg_lookup = {1'b1, IDX_TURN_ON_DELAY};
      OFF_SOFT_START:  reg_lookup = {1'b1, IDX_SOFT_START};
      OFF_TURN_OFF_DELAY:  reg_lookup = {1'b1, IDX_TURN_OFF_DELAY};
      OFF_SOFT_STOP:   reg_lookup = {1'b1, IDX_SOFT_STOP};
      OFF_MAXCAP_H:    reg_lookup = {1'b1, IDX_MAXCAP_H};
      OFF_MAXCAP_L:    reg_lookup = {1'b1, IDX_MAXCAP_L};
      OFF_SYSCFG:      reg_lookup = {1'b1, IDX_SYSCFG};
      OFF_REGBUS_ADDR: reg_lookup = {1'b1, IDX_REGBUS_ADDR};
      OFF_TARGET_ADDR: reg_lookup = {1'b1, IDX_TARGET_ADDR};
      OFF_VOUT_OFFSET: reg_lookup = {1'b1, IDX_VOUT_OFFSET};
      OFF_PROTOCOL:    reg_lookup = {1'b1, IDX_PROTOCOL};
      default:         reg_lookup = '0;
    endcase
  endfunction

  function automatic logic is_protected(input logic [IDXW-1:0] idx);
    is_protected = (idx >= IDX_TURN_ON_DELAY) && (idx <= IDX_MAXCAP_L);
  endfunction

  function automatic logic [7:0] stage_mask(input logic [IDXW-1:0] idx, input logic [1:0] outctl);
    unique case (idx)
      IDX_SYSCFG:      stage_mask = SYSCFG_STAGE_MASK;
      IDX_REGBUS_ADDR: stage_mask = FULL_MASK;
      IDX_PROTOCOL:    stage_mask = PROTOCOL_STAGE_MASK;
      IDX_VOUT_OFFSET: stage_mask = (outctl == OUTCTL_OFFSET_MODE) ? FULL_MASK : 8'h00;
      default:         stage_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] reset_value(input int idx);
    reset_value = (idx == int'(IDX_ON_OFF)) ? RST_ON_OFF : RST_ZERO;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  i2ccf_bus_type       st_r, st_nxt;
  i2ccf_phase_type     ph_r, ph_nxt;
  logic                scl_q_r, scl_q_nxt;
  logic                sda_q_r, sda_q_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic [7:0]          sh_r, sh_nxt;
  logic [7:0]          tx_r, tx_nxt;
  logic [7:0]          ptr_r, ptr_nxt;
  logic                oe_r, oe_nxt;
  logic                wr_stb;

  i2ccf_nvm_type       nv_r, nv_nxt;
  logic [IDXW-1:0]     idx_r, idx_nxt;
  logic [TMRW-1:0]     tmr_r, tmr_nxt;
  logic [7:0]          wr_r   [NREG];
  logic [7:0]          wr_nxt [NREG];
  logic [7:0]          act_r  [NREG];
  logic [7:0]          act_nxt[NREG];
  logic [NREG-1:0]     hold_r, hold_nxt;
  logic [1:0]          step_r, step_nxt;
  logic [6:0]          addr_r, addr_nxt;

  logic                scl_rise, scl_fall, bus_start, bus_stop;
  logic [IDXW:0]       look;
  logic                unlocked, always_on, wr_allow;
  logic [7:0]          rd_data;

  assign sda_o          = 1'b0;
  assign sda_oe         = oe_r;
  assign target_address = addr_r;
  assign unlocked       = (step_r == 2'(PASS_COUNT));
  assign regs_unlocked  = unlocked;
  assign nvm_busy       = (nv_r != NV_IDLE);
  assign always_on      = ~wr_r[IDX_ON_OFF][ONOFF_PIN_CTRL_BIT];

  // Oversampled edges; the 50 MHz clock leaves many samples per bit at 1 MHz.
  assign scl_rise  = scl_i & ~scl_q_r;
  assign scl_fall  = ~scl_i & scl_q_r;
  assign bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign look      = reg_lookup(ptr_r);

  ////////////////////////////////////////////////////////////////////////////
  // Write acceptance and read data.

  always_comb
  begin
    if (ptr_r == OFF_LOCK)
      wr_allow = 1'b1;
    else if (!unlocked || nvm_busy)
      wr_allow = 1'b0;
    else if (ptr_r == OFF_RESTORE)
      wr_allow = ~switching_en;
    else if (ptr_r == OFF_COMMIT)
      wr_allow = 1'b1;
    else if (look[IDXW])
      wr_allow = ~(is_protected(look[IDXW-1:0]) & switching_en);
    else
      wr_allow = 1'b0;
  end

  always_comb
  begin
    if (ptr_r == OFF_LOCK)
      rd_data = {7'h00, unlocked};
    else if (look[IDXW])
      rd_data = wr_r[look[IDXW-1:0]];
    else
      rd_data = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine.

  always_comb
  begin
    st_nxt    = st_r;
    ph_nxt    = ph_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    oe_nxt    = oe_r;
    scl_q_nxt = scl_i;
    sda_q_nxt = sda_i;
    wr_stb    = 1'b0;
    if (bus_start)
    begin
      st_nxt  = ST_RX;
      ph_nxt  = PH_ADDR;
      cnt_nxt = 3'd0;
      oe_nxt  = 1'b0;
    end
    else if (bus_stop)
    begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
        begin
        end
        ST_RX:
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_i};
            cnt_nxt = cnt_r + 3'd1;
            if (cnt_r == 3'd7)
              st_nxt = ST_ACKPEND;
          end
        ST_ACKPEND:
          if (scl_fall)
          begin
            st_nxt = ST_IDLE;
            unique case (ph_r)
              PH_ADDR:
                if ((sh_r[7:1] == addr_r) && (nv_r != NV_INIT))
                begin
                  oe_nxt = 1'b1;
                  st_nxt = ST_ACK;
                  ph_nxt = (sh_r[0] == RW_WRITE) ? PH_CMD : PH_READ;
                end
              PH_CMD:
              begin
                ptr_nxt = sh_r;
                oe_nxt  = 1'b1;
                st_nxt  = ST_ACK;
                ph_nxt  = PH_DATA;
              end
              default:
                if (wr_allow)
                begin
                  wr_stb = 1'b1;
                  oe_nxt = 1'b1;
                  st_nxt = ST_ACK;
                end
            endcase
          end
        ST_ACK:
          if (scl_fall)
          begin
            cnt_nxt = 3'd0;
            if (ph_r == PH_READ)
            begin
              tx_nxt = rd_data;
              oe_nxt = ~rd_data[7];
              st_nxt = ST_TX;
            end
            else
            begin
              oe_nxt = 1'b0;
              st_nxt = ST_RX;
            end
          end
        ST_TX:
          if (scl_rise)
          begin
            cnt_nxt = cnt_r + 3'd1;
            if (cnt_r == 3'd7)
              st_nxt = ST_TXREL;
          end
          else if (scl_fall)
          begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = ~tx_r[6];
          end
        ST_TXREL:
          if (scl_fall)
          begin
            oe_nxt = 1'b0;
            st_nxt = ST_MACK;
          end
        ST_MACK:
          if (scl_rise)
            st_nxt = sda_i ? ST_IDLE : ST_ACK;
        default:
          st_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r    <= ST_IDLE;
      ph_r    <= PH_ADDR;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r   <= 3'd0;
      sh_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
      oe_r    <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      ph_r    <= ph_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      oe_r    <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, lock and NVM sequencer.

  always_comb
  begin
    logic [7:0] m;
    m         = 8'h00;
    nv_nxt    = nv_r;
    idx_nxt   = idx_r;
    tmr_nxt   = tmr_r;
    hold_nxt  = hold_r;
    step_nxt  = step_r;
    addr_nxt  = addr_r;
    wr_nxt    = wr_r;
    nvm_addr  = idx_r;
    nvm_wdata = wr_r[idx_r];
    nvm_we    = 1'b0;
    if (wr_stb)
    begin
      if (ptr_r == OFF_LOCK)
      begin
        if (!unlocked && (sh_r == PASSCODES[(PASS_COUNT-1-int'(step_r))*8 +: 8]))
          step_nxt = step_r + 2'd1;
        else
          step_nxt = 2'd0;
      end
      else if (ptr_r == OFF_COMMIT)
      begin
        if (sh_r[ACTION_BIT])
        begin
          nv_nxt  = NV_STORE;
          idx_nxt = '0;
        end
      end
      else if (ptr_r == OFF_RESTORE)
      begin
        if (sh_r[ACTION_BIT])
        begin
          nv_nxt  = NV_RESTORE;
          idx_nxt = '0;
        end
      end
      else
      begin
        wr_nxt[look[IDXW-1:0]]   = sh_r;
        hold_nxt[look[IDXW-1:0]] = 1'b0;
      end
    end
    unique case (nv_r)
      NV_INIT, NV_RESTORE:
      begin
        if (!(always_on && is_protected(idx_r)))
        begin
          wr_nxt[idx_r]   = nvm_rdata;
          hold_nxt[idx_r] = always_on && (stage_mask(idx_r, act_r[IDX_SYSCFG][OUTCTL_LSB +: 2]) != 8'h00);
        end
        idx_nxt = idx_r + 4'd1;
        if (idx_r == IDX_LAST)
        begin
          nv_nxt = NV_IDLE;
          if (nv_r == NV_INIT)
          begin
            if (wr_r[IDX_SYSCFG][SYSCFG_ADDR_OVRD_BIT])
              addr_nxt = wr_r[IDX_TARGET_ADDR][6:0];
            else
              addr_nxt = {STRAP_ADDR_HIGH, strap_level};
          end
        end
      end
      NV_STORE:
      begin
        nvm_we  = 1'b1;
        idx_nxt = idx_r + 4'd1;
        if (idx_r == IDX_LAST)
        begin
          nv_nxt  = NV_WAIT;
          tmr_nxt = '0;
        end
      end
      NV_WAIT:
      begin
        tmr_nxt = tmr_r + TMRW'(1);
        if (tmr_r == TMRW'(STORE_WAIT - 1))
          nv_nxt = NV_IDLE;
      end
      NV_IDLE:
      begin
      end
      default:
        nv_nxt = NV_IDLE;
    endcase
    for (int i = 0; i < NREG; i++)
    begin
      m = stage_mask(IDXW'(i), act_r[IDX_SYSCFG][OUTCTL_LSB +: 2]);
      if (switching_en || hold_nxt[i])
        act_nxt[i] = (wr_nxt[i] & ~m) | (act_r[i] & m);
      else
        act_nxt[i] = wr_nxt[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nv_r   <= NV_INIT;
      idx_r  <= '0;
      tmr_r  <= '0;
      hold_r <= '0;
      step_r <= 2'd0;
      addr_r <= 7'h7F;
      for (int i = 0; i < NREG; i++)
      begin
        wr_r[i]  <= reset_value(i);
        act_r[i] <= reset_value(i);
      end
    end
    else
    begin
      nv_r   <= nv_nxt;
      idx_r  <= idx_nxt;
      tmr_r  <= tmr_nxt;
      hold_r <= hold_nxt;
      step_r <= step_nxt;
      addr_r <= addr_nxt;
      wr_r   <= wr_nxt;
      act_r  <= act_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NREG; i++)
      cfg_active[i*8 +: 8] = act_r[i];
  end

endmodule

// ---- tb/i2ccf_port_props.sv ----
// Concurrent checks on the pins of the configuration port.
`timescale 1ns/10ps

module i2ccf_port_props
  import i2ccf_pkg::*;
#(
  parameter int STORE_WAIT = STORE_CYCLES
)
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              scl_i,
  input wire logic              sda_oe,
  input wire logic [3:0]        strap_level,
  input wire logic [IDXW-1:0]   nvm_addr,
  input wire logic              nvm_we,
  input wire logic [6:0]        target_address,
  input wire logic              nvm_busy,
  input wire logic [NREG*8-1:0] cfg_active
);
  logic        init_r;
  logic        wait_r;
  logic [31:0] cnt_r;
  logic [31:0] icnt_r;
  logic [4:0]  wcnt_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Marks the power-on load and the wait that follows each commit walk.
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      init_r <= 1'b1;
      wait_r <= 1'b0;
      cnt_r  <= '0;
      icnt_r <= '0;
      wcnt_r <= '0;
    end
    else
    begin
      init_r <= init_r & nvm_busy;
      icnt_r <= icnt_r + {31'h0, init_r};
      wait_r <= nvm_we | (wait_r & nvm_busy);
      cnt_r  <= nvm_we ? '0 : cnt_r + 32'h1;
      wcnt_r <= nvm_we ? wcnt_r + 5'h1 : '0;
    end

  ////////////////////////////////////////////////////////////////////////////////
  bus_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda changed while scl high");
  init_nack_a: assert property (init_r |-> !sda_oe)
    else $error("bus answered during power-on load");
  strap_addr_a: assert property (init_r && !nvm_busy |-> target_address ==
    (cfg_active[8*IDX_SYSCFG] ? cfg_active[8*IDX_TARGET_ADDR +: 7] : {STRAP_ADDR_HIGH, strap_level}))
    else $error("wrong target address after load");
  addr_hold_a: assert property ($changed(target_address) |-> init_r)
    else $error("target address moved after load");
  init_len_a: assert property (init_r && !nvm_busy |-> icnt_r == NREG)
    else $error("power-on load length wrong");
  we_start_a: assert property ($rose(nvm_we) |-> nvm_addr == '0 && $rose(nvm_busy))
    else $error("commit walk started wrongly");
  we_walk_a: assert property (nvm_we && $past(nvm_we) |-> nvm_addr == $past(nvm_addr) + 4'h1)
    else $error("commit walk skipped an entry");
  we_count_a: assert property ($fell(nvm_we) |-> wcnt_r == 5'(NREG))
    else $error("commit walk length wrong");
  store_wait_a: assert property (wait_r && !nvm_busy |-> cnt_r inside {[STORE_WAIT-1:STORE_WAIT+1]})
    else $error("commit wait length wrong");
endmodule

// ---- tb/i2ccf_host.sv ----
// I2C host model driving the configuration port.
`timescale 1ns/10ps

module i2ccf_host
  import i2ccf_pkg::*;
#(
  parameter int Q = 13
)
(
  input  wire logic mclk,
  input  wire logic dev_oe,
  output logic      scl,
  output wire logic sda
);
  logic sda_r;

  // Released data floats high through the pull-up.
  assign sda = sda_r & ~dev_oe;

  initial
  begin
    scl   = 1'b1;
    sda_r = 1'b1;
  end

  task automatic hq();
    repeat (Q) @(posedge mclk);
  endtask

  // A start when p is 0, a stop when p is 1.
  task automatic cond(input logic p);
    sda_r <= ~p;
    hq();
    scl <= 1'b1;
    hq();
    sda_r <= p;
    hq();
    if (!p)
      scl <= 1'b0;
  endtask

  task automatic bx(input logic b, output logic r);
    sda_r <= b;
    hq();
    scl <= 1'b1;
    hq();
    r = sda;
    hq();
    scl <= 1'b0;
    hq();
  endtask

  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bx(d[i], r);
      q[i] = r;
    end
    bx(a, r);
    ack = ~r;
  endtask

  // Writes carry no checking byte after the data.
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k1;
    logic       k2;
    logic       k3;
    cond(1'b0);
    xb({a, RW_WRITE}, 1'b1, q, k1);
    xb(c, 1'b1, q, k2);
    xb(d, 1'b1, q, k3);
    cond(1'b1);
    ok = k1 & k2 & k3;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k1;
    logic       k2;
    logic       k3;
    logic       k4;
    cond(1'b0);
    xb({a, RW_WRITE}, 1'b1, q, k1);
    xb(c, 1'b1, q, k2);
    cond(1'b0);
    xb({a, 1'b1}, 1'b1, q, k3);
    xb(8'hFF, 1'b1, d, k4);
    cond(1'b1);
    ok = k1 & k2 & k3;
  endtask
endmodule

// ---- tb/i2c_config_port_nvm_lock_test.sv ----
// Self-checking bench for the configuration port.
`timescale 1ns/10ps

module i2c_config_port_nvm_lock_test
  import i2ccf_pkg::*;
;
  localparam int          SW = 200;
  localparam logic [15:0] PC = 16'h5AC3;
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [3:0]             strap = 4'h0;
  logic                   sw_en = 1'b0;
  wire                    scl;
  wire                    sda;
  wire                    sda_oe;
  wire [IDXW-1:0]         nvm_addr;
  wire [7:0]              nvm_wdata;
  wire                    nvm_we;
  wire [6:0]              tgt;
  wire                    unl;
  wire                    busy;
  wire [NREG*8-1:0]       cfg;
  logic [7:0]             nvm [16];
  wire [7:0]              nvm_rd = nvm[nvm_addr];
  logic [6:0]             me;
  logic [7:0]             prot [7] = '{OFF_RESTORE, OFF_TURN_ON_DELAY, OFF_SOFT_START, OFF_TURN_OFF_DELAY,
                                       OFF_SOFT_STOP, OFF_MAXCAP_H, OFF_MAXCAP_L};
  logic [7:0]             soff [3] = '{OFF_REGBUS_ADDR, OFF_PROTOCOL, OFF_SYSCFG};
  int                     sidx [3] = '{8, 11, 7};
  logic [7:0]             smsk [3] = '{FULL_MASK, PROTOCOL_STAGE_MASK, SYSCFG_STAGE_MASK};
  logic [7:0]             old [3];
  logic [7:0]             nv [3];
  int                     errors = 0;
  int                     cmp_count = 0;

  always #10 mclk = ~mclk;

  always @(posedge mclk)
    if (nvm_we)
      nvm[nvm_addr] <= nvm_wdata;

  i2ccf_host h (.mclk(mclk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  i2ccf_port #(.STORE_WAIT(SW), .PASSCODES(PC)) DUT (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .strap_level(strap), .switching_en(sw_en), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_we(nvm_we), .nvm_rdata(nvm_rd), .target_address(tgt), .regs_unlocked(unl),
    .nvm_busy(busy), .cfg_active(cfg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] cfg_b(input int i);
    return cfg[i*8 +: 8];
  endfunction

  // Staged bits keep the old value, the rest follow the write.
  function automatic logic [7:0] held(input logic [7:0] o, input logic [7:0] n, input logic [7:0] m);
    return (o & m) | (n & ~m);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatched %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic w(input logic [7:0] c, input logic [7:0] d, input logic exp);
    logic ok;
    h.wr(me, c, d, ok);
    check({7'h0, ok}, {7'h0, exp});
  endtask

  task automatic r(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    h.rd(me, c, d, ok);
    check({7'h0, ok}, 8'h01);
    check(d, exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 1000)
      errors++;
  endtask

  task automatic power_up();
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    check(cfg_b(0), RST_ON_OFF);
    check({7'h0, unl}, 8'h00);
    rst_n <= 1'b1;
    @(posedge mclk);
    wait_idle();
  endtask

  task automatic unlock();
    w(OFF_LOCK, PC[15:8], 1'b1);
    w(OFF_LOCK, PC[7:0], 1'b1);
    check({7'h0, unl}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] v;
    logic [7:0] x;
    logic [7:0] y;
    logic [6:0] p;
    logic       ok;
    void'($urandom(32'hf3f8));
    for (int i = 0; i < 16; i++)
      nvm[i] = 8'($urandom);
    nvm[0] = RST_ON_OFF;
    nvm[7] = nvm[7] & 8'hFE;
    strap <= 4'($urandom);
    power_up();
    me = {STRAP_ADDR_HIGH, strap};
    check({1'b0, tgt}, {1'b0, me});
    for (int i = 0; i < NREG; i++)
      check(cfg_b(i), nvm[i]);
    h.wr(me ^ 7'h08, OFF_LOCK, PC[15:8], ok);
    check({7'h0, ok}, 8'h00);
    w(OFF_TURN_ON_DELAY, 8'h33, 1'b0);
    r(OFF_TURN_ON_DELAY, nvm[1]);
    w(OFF_LOCK, PC[15:8], 1'b1);
    w(OFF_LOCK, 8'h11, 1'b1);
    w(OFF_LOCK, PC[7:0], 1'b1);
    check({7'h0, unl}, 8'h00);
    unlock();
    r(OFF_LOCK, 8'h01);
    $display("test 1 done");
    x = nvm[1];
    v = ~nvm[1];
    w(OFF_TURN_ON_DELAY, v, 1'b1);
    check(cfg_b(1), v);
    sw_en <= 1'b1;
    foreach (prot[i])
      w(prot[i], 8'h00, 1'b0);
    check(cfg_b(1), v);
    check(nvm[1], x);
    $display("test 2 done");
    foreach (soff[i])
    begin
      old[i] = cfg_b(sidx[i]);
      nv[i]  = (8'($urandom) & 8'hE6) | 8'h09;
      w(soff[i], nv[i], 1'b1);
      check(cfg_b(sidx[i]), held(old[i], nv[i], smsk[i]));
      r(soff[i], nv[i]);
    end
    check({1'b0, tgt}, {1'b0, me});
    sw_en <= 1'b0;
    repeat (3) @(posedge mclk);
    foreach (soff[i])
      check(cfg_b(sidx[i]), nv[i]);
    sw_en <= 1'b1;
    x = cfg_b(10);
    v = ~x;
    w(OFF_VOUT_OFFSET, v, 1'b1);
    check(cfg_b(10), x);
    sw_en <= 1'b0;
    repeat (3) @(posedge mclk);
    check(cfg_b(10), v);
    $display("test 3 done");
    p = {1'b0, 6'($urandom)};
    w(OFF_TARGET_ADDR, {1'b0, p}, 1'b1);
    r(OFF_TARGET_ADDR, {1'b0, p});
    check({1'b0, tgt}, {1'b0, me});
    w(OFF_COMMIT, 8'h01, 1'b1);
    check({7'h0, busy}, 8'h01);
    wait_idle();
    check(nvm[9], {1'b0, p});
    check(nvm[7], nv[2]);
    power_up();
    check({1'b0, tgt}, {1'b0, p});
    h.wr(me, OFF_LOCK, PC[15:8], ok);
    check({7'h0, ok}, 8'h00);
    me = p;
    $display("test 4 done");
    unlock();
    w(OFF_SOFT_START, ~nvm[2], 1'b1);
    w(OFF_RESTORE, 8'h01, 1'b1);
    wait_idle();
    check(cfg_b(2), nvm[2]);
    w(OFF_ON_OFF, 8'h00, 1'b1);
    w(OFF_COMMIT, 8'h01, 1'b1);
    wait_idle();
    x = ~nvm[1];
    y = ~nvm[8];
    w(OFF_TURN_ON_DELAY, x, 1'b1);
    w(OFF_REGBUS_ADDR, y, 1'b1);
    w(OFF_RESTORE, 8'h01, 1'b1);
    wait_idle();
    check(cfg_b(1), x);
    check(cfg_b(8), y);
    power_up();
    check(cfg_b(1), RST_ZERO);
    check(cfg_b(8), RST_ZERO);
    $display("test 5 done");
    stop_test();
  end

  initial
  begin
    repeat (90_000) @(posedge mclk);
    errors++;
    stop_test();
  end
endmodule

bind i2ccf_port i2ccf_port_props #(.STORE_WAIT(STORE_WAIT)) u_props (
  .mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_oe(sda_oe), .strap_level(strap_level),
  .nvm_addr(nvm_addr), .nvm_we(nvm_we), .target_address(target_address), .nvm_busy(nvm_busy),
  .cfg_active(cfg_active)
);
